/* src/hbdpc_pkg.sv */
// package for the h-bridge drive protection controller
package hbdpc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SLEEP_MS = 10;
  // longer than 10 ms: one cycle past the exact count
  localparam int SLEEP_CYC = SLEEP_MS * (CLK_HZ / 1000) + 1;
  localparam int DEGLITCH_CYC = 20;
  localparam int RETRY_CYC = 10_000;
  localparam int CNT_W = 18;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    HBDPC_STANDBY = 2'b00,
    HBDPC_REVERSE = 2'b01,
    HBDPC_FORWARD = 2'b10,
    HBDPC_BRAKE = 2'b11
  } hbdpc_mode_t;

  typedef enum logic [1:0] {
    HBDPC_RUN = 2'b00,
    HBDPC_OC_HOLD = 2'b01,
    HBDPC_SC_HOLD = 2'b10
  } hbdpc_prot_t;

  // analog comparator flags, hysteresis already resolved
  typedef struct packed {
    logic supplyLockout;
    logic overcurrent;
    logic shortCircuit;
    logic overTemp;
  } hbdpc_flags_t;

  // power switches: high a, low a, high b, low b
  typedef struct packed {
    logic highSwitchA;
    logic lowSwitchA;
    logic highSwitchB;
    logic lowSwitchB;
  } hbdpc_switch_t;

  typedef struct packed {
    hbdpc_switch_t sw;
    logic sleeping;
    logic faultOff;
    hbdpc_prot_t prot;
    logic [CNT_W-1:0] idleCnt;
    logic [CNT_W-1:0] deglCnt;
    logic [CNT_W-1:0] retryCnt;
    hbdpc_flags_t flagSync1;
    hbdpc_flags_t flagSync2;
  } hbdpc_state_t;

endpackage : hbdpc_pkg

/* src/hbdpc_ctrl.sv */
// h-bridge drive decode, sleep and protection logic
`timescale 1ns/1ps
// Overview of operation
// [RL1] inputs 00 standby, 01 reverse, 10 forward, 11 brake.
// [RL2] switch pattern per mode: off, 2+3, 1+4, 2+4.
// [RL3] standby held longer than 10 ms enters sleep, outputs stay off.
// [RL4] sleep powers down protection; only standby is available.
// [RL5] either drive input high leaves sleep.
// [RL6] supply lockout forces all off and ignores inputs.
// [RL7] overcurrent persisting past deglitch time switches all off.
// [RL8] after overcurrent shutdown wait retry period then resume.
// [RL9] short circuit switches all off at once, no deglitch.
// [RL10] after short, recheck every retry period until cleared.
// [RL11] overtemperature forces all off in every mode until recovery.
// [RL12] lockout, overcurrent, short guards act only in forward, reverse, brake.
// [RL13] host sets its two pins as outputs before driving.
// [RL14] undriven drive inputs read low, giving standby.
// [RL15] deglitch and retry are cycle counts from the block clock.
// [RL16] analog comparisons enter as synchronised single-bit flags.
module hbdpc_ctrl
  import hbdpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // drive inputs from the host
  input wire logic driveInputA,
  input wire logic driveInputB,
  // comparator flags
  input wire hbdpc_pkg::hbdpc_flags_t flagsIn,
  // bridge switches and status
  output hbdpc_pkg::hbdpc_switch_t switches,
  output logic sleepPeriod,
  output logic protectOff
);
  import hbdpc_pkg::*;

  hbdpc_state_t s_q;
  hbdpc_state_t s_d;
  hbdpc_mode_t mode;
  logic guarded;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic hbdpc_switch_t modeSwitches(input hbdpc_mode_t m);
    hbdpc_switch_t r;
    r = '0;
    case (m)
      HBDPC_REVERSE: r = '{highSwitchA: 1'b0, lowSwitchA: 1'b1, highSwitchB: 1'b1, lowSwitchB: 1'b0}; // [RL2]
      HBDPC_FORWARD: r = '{highSwitchA: 1'b1, lowSwitchA: 1'b0, highSwitchB: 1'b0, lowSwitchB: 1'b1}; // [RL2]
      HBDPC_BRAKE: r = '{highSwitchA: 1'b0, lowSwitchA: 1'b1, highSwitchB: 1'b0, lowSwitchB: 1'b1}; // [RL2]
      default: r = '0;
    endcase
    return r;
  endfunction : modeSwitches

  // pull-downs live in the pad; an open pin arrives as 0 and decodes as standby [RL14]
  assign mode = hbdpc_mode_t'({driveInputA, driveInputB}); // [RL1]
  // guards only matter outside standby and never while asleep [RL12] [RL4]
  assign guarded = (mode != HBDPC_STANDBY) && !s_q.sleeping;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    // two-flop synchroniser; stage one only feeds stage two [RL16]
    s_d.flagSync1 = flagsIn;
    s_d.flagSync2 = s_q.flagSync1;

    // sleep entry and exit
    if (mode != HBDPC_STANDBY)
    begin
      s_d.sleeping = 1'b0; // [RL5]
      s_d.idleCnt = '0;
    end
    else if (!s_q.sleeping)
    begin
      if (s_q.idleCnt >= CNT_W'(SLEEP_CYC - 1))
        s_d.sleeping = 1'b1; // [RL3]
      else
        s_d.idleCnt = s_q.idleCnt + 1'b1;
    end

    // overcurrent deglitch, counted only while guarded [RL15]
    if (guarded && s_q.flagSync2.overcurrent)
    begin
      if (s_q.deglCnt < CNT_W'(DEGLITCH_CYC))
        s_d.deglCnt = s_q.deglCnt + 1'b1;
    end
    else
      s_d.deglCnt = '0;

    case (s_q.prot)
      HBDPC_RUN:
      begin
        s_d.retryCnt = '0;
        if (guarded && s_q.flagSync2.shortCircuit)
          s_d.prot = HBDPC_SC_HOLD; // [RL9]
        else if (guarded && s_q.deglCnt >= CNT_W'(DEGLITCH_CYC))
          s_d.prot = HBDPC_OC_HOLD; // [RL7]
      end
      HBDPC_OC_HOLD:
      begin
        if (s_q.retryCnt >= CNT_W'(RETRY_CYC - 1))
        begin
          s_d.prot = HBDPC_RUN; // [RL8]
          s_d.retryCnt = '0;
          s_d.deglCnt = '0;
        end
        else
          s_d.retryCnt = s_q.retryCnt + 1'b1;
      end
      HBDPC_SC_HOLD:
      begin
        if (s_q.retryCnt >= CNT_W'(RETRY_CYC - 1))
        begin
          s_d.retryCnt = '0;
          // check the output once per retry period [RL10]
          if (!s_q.flagSync2.shortCircuit)
            s_d.prot = HBDPC_RUN;
        end
        else
          s_d.retryCnt = s_q.retryCnt + 1'b1;
      end
      default:
        s_d.prot = HBDPC_RUN;
    endcase

    // leaving the guarded modes drops any retry in progress [RL12]
    if (!guarded)
      s_d.prot = HBDPC_RUN;

    // output decision from next protection state
    s_d.faultOff = s_q.flagSync2.overTemp // [RL11]
                 || (guarded && s_q.flagSync2.supplyLockout) // [RL6]
                 || (s_d.prot != HBDPC_RUN); // [RL7] [RL9]
    // asleep only standby exists, which is all-off already [RL4]
    s_d.sw = s_d.faultOff ? hbdpc_switch_t'('0) : modeSwitches(mode); // [RL2]
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign switches = s_q.sw;
  assign sleepPeriod = s_q.sleeping;
  assign protectOff = s_q.faultOff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence scSeen_s;
    guarded && s_q.flagSync2.shortCircuit && s_q.prot == HBDPC_RUN;
  endsequence
  sequence ocWait_s;
    guarded && s_q.prot == HBDPC_OC_HOLD && s_q.retryCnt != CNT_W'(RETRY_CYC - 1);
  endsequence
  sequence scFree_s;
    guarded && s_q.prot == HBDPC_SC_HOLD && s_q.retryCnt == CNT_W'(RETRY_CYC - 1) && !s_q.flagSync2.shortCircuit;
  endsequence
  sequence scStuck_s;
    guarded && s_q.prot == HBDPC_SC_HOLD && s_q.retryCnt == CNT_W'(RETRY_CYC - 1) && s_q.flagSync2.shortCircuit;
  endsequence

  decode_forward_a: assert property (@(posedge mclk) disable iff (rst) // [RL1]
    (mode == HBDPC_FORWARD && !s_d.faultOff) |=> switches.highSwitchA && switches.lowSwitchB)
    else $error("forward pattern wrong");
  bridge_pattern_a: assert property (@(posedge mclk) disable iff (rst) // [RL2]
    !(switches.highSwitchA && switches.lowSwitchA) && !(switches.highSwitchB && switches.lowSwitchB))
    else $error("shoot-through pattern");
  sleep_entry_a: assert property (@(posedge mclk) disable iff (rst) // [RL3]
    $rose(sleepPeriod) |-> $past(mode) == HBDPC_STANDBY && $past(s_q.idleCnt) == CNT_W'(SLEEP_CYC - 1))
    else $error("sleep entered early");
  sleep_outputs_a: assert property (@(posedge mclk) disable iff (rst) // [RL4]
    sleepPeriod |-> switches == '0 && s_q.prot == HBDPC_RUN)
    else $error("switch on while asleep");
  sleep_exit_a: assert property (@(posedge mclk) disable iff (rst) // [RL5]
    (sleepPeriod && (driveInputA || driveInputB)) |=> !sleepPeriod)
    else $error("sleep not left");
  lockout_off_a: assert property (@(posedge mclk) disable iff (rst) // [RL6]
    (s_q.flagSync2.supplyLockout && guarded) |=> switches == '0)
    else $error("lockout ignored");
  oc_trip_a: assert property (@(posedge mclk) disable iff (rst) // [RL7]
    (guarded && s_q.prot == HBDPC_RUN && !s_q.flagSync2.shortCircuit && s_q.deglCnt >= CNT_W'(DEGLITCH_CYC))
    |=> s_q.prot == HBDPC_OC_HOLD && switches == '0)
    else $error("overcurrent not tripped");
  oc_retry_a: assert property (@(posedge mclk) disable iff (rst) // [RL8]
    (s_q.prot == HBDPC_OC_HOLD && guarded && s_q.retryCnt == CNT_W'(RETRY_CYC - 1)) |=> s_q.prot == HBDPC_RUN)
    else $error("retry did not release");
  sc_trip_a: assert property (@(posedge mclk) disable iff (rst) // [RL9]
    scSeen_s |=> switches == '0 ##0 s_q.prot == HBDPC_SC_HOLD)
    else $error("short not tripped");
  sc_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RL10]
    (s_q.prot == HBDPC_SC_HOLD && guarded && s_q.retryCnt != CNT_W'(RETRY_CYC - 1)) |=> s_q.prot == HBDPC_SC_HOLD)
    else $error("short released off-period");
  temp_off_a: assert property (@(posedge mclk) disable iff (rst) // [RL11]
    s_q.flagSync2.overTemp |=> switches == '0)
    else $error("overtemp ignored");
  standby_free_a: assert property (@(posedge mclk) disable iff (rst) // [RL12]
    (mode == HBDPC_STANDBY) |=> s_q.prot == HBDPC_RUN)
    else $error("guard active in standby");

  // ----------------------------------------
  // checks: decode and sleep
  // ----------------------------------------
  decode_reverse_a: assert property (@(posedge mclk) disable iff (rst) // [RL1]
    (mode == HBDPC_REVERSE && !s_d.faultOff)
    |=> switches.lowSwitchA && switches.highSwitchB && !switches.highSwitchA && !switches.lowSwitchB)
    else $error("reverse pattern wrong");
  decode_brake_a: assert property (@(posedge mclk) disable iff (rst) // [RL1]
    (mode == HBDPC_BRAKE && !s_d.faultOff)
    |=> switches.lowSwitchA && switches.lowSwitchB && !switches.highSwitchA && !switches.highSwitchB)
    else $error("brake pattern wrong");
  forward_only_a: assert property (@(posedge mclk) disable iff (rst) // [RL2]
    (mode == HBDPC_FORWARD && !s_d.faultOff)
    |=> !switches.lowSwitchA && !switches.highSwitchB)
    else $error("forward extra switch on");
  standby_off_a: assert property (@(posedge mclk) disable iff (rst) // [RL2]
    (mode == HBDPC_STANDBY)
    |=> switches == '0)
    else $error("switch on in standby");
  // sleep needs 10 ms of standby, far longer than a short run reaches
  sleep_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RL3]
    (sleepPeriod && mode == HBDPC_STANDBY)
    |=> sleepPeriod)
    else $error("sleep left in standby");
  sleep_early_a: assert property (@(posedge mclk) disable iff (rst) // [RL3]
    (!sleepPeriod && mode == HBDPC_STANDBY && s_q.idleCnt < CNT_W'(SLEEP_CYC - 1))
    |=> !sleepPeriod)
    else $error("sleep before standby time");
  idle_clear_a: assert property (@(posedge mclk) disable iff (rst) // [RL5]
    (mode != HBDPC_STANDBY)
    |=> s_q.idleCnt == '0 && !sleepPeriod)
    else $error("standby count not cleared");
  sleep_unguarded_a: assert property (@(posedge mclk) disable iff (rst) // [RL4]
    (sleepPeriod && mode == HBDPC_STANDBY && !s_q.flagSync2.overTemp)
    |=> !protectOff)
    else $error("guard active while asleep");

  // ----------------------------------------
  // checks: protection timing
  // ----------------------------------------
  lockout_flag_a: assert property (@(posedge mclk) disable iff (rst) // [RL6]
    (guarded && s_q.flagSync2.supplyLockout)
    |=> protectOff)
    else $error("lockout flag missing");
  protect_blank_a: assert property (@(posedge mclk) disable iff (rst) // [RL7]
    protectOff
    |-> switches == '0)
    else $error("switch on while protected");
  oc_filter_a: assert property (@(posedge mclk) disable iff (rst) // [RL7]
    (guarded && s_q.prot == HBDPC_RUN && !s_q.flagSync2.shortCircuit && s_q.deglCnt < CNT_W'(DEGLITCH_CYC))
    |=> s_q.prot == HBDPC_RUN)
    else $error("overcurrent tripped early");
  oc_wait_a: assert property (@(posedge mclk) disable iff (rst) // [RL8]
    ocWait_s
    |=> s_q.prot == HBDPC_OC_HOLD && switches == '0)
    else $error("overcurrent hold released early");
  oc_count_a: assert property (@(posedge mclk) disable iff (rst) // [RL15]
    ocWait_s
    |=> s_q.retryCnt == $past(s_q.retryCnt) + 1'b1)
    else $error("retry count stalled");
  degl_cap_a: assert property (@(posedge mclk) disable iff (rst) // [RL15]
    (guarded && s_q.flagSync2.overcurrent)
    |=> s_q.deglCnt <= CNT_W'(DEGLITCH_CYC))
    else $error("deglitch count overrun");
  retry_cap_a: assert property (@(posedge mclk) disable iff (rst) // [RL15]
    (s_q.prot != HBDPC_RUN)
    |-> s_q.retryCnt < CNT_W'(RETRY_CYC))
    else $error("retry count overrun");
  sc_direct_a: assert property (@(posedge mclk) disable iff (rst) // [RL9]
    (guarded && s_q.flagSync2.shortCircuit && s_q.prot != HBDPC_OC_HOLD)
    |=> switches == '0)
    else $error("short left switches on");
  sc_release_a: assert property (@(posedge mclk) disable iff (rst) // [RL10]
    scFree_s
    |=> s_q.prot == HBDPC_RUN && s_q.retryCnt == '0)
    else $error("cleared short not released");
  sc_recheck_a: assert property (@(posedge mclk) disable iff (rst) // [RL10]
    scStuck_s
    |=> s_q.prot == HBDPC_SC_HOLD && s_q.retryCnt == '0 && switches == '0)
    else $error("standing short released");
  temp_flag_a: assert property (@(posedge mclk) disable iff (rst) // [RL11]
    s_q.flagSync2.overTemp
    |=> protectOff)
    else $error("overtemp flag missing");
  standby_quiet_a: assert property (@(posedge mclk) disable iff (rst) // [RL12]
    (mode == HBDPC_STANDBY && !s_q.flagSync2.overTemp)
    |=> !protectOff)
    else $error("standby fault flagged");
  sync_first_a: assert property (@(posedge mclk) disable iff (rst) // [RL16]
    !$past(rst)
    |-> s_q.flagSync1 == $past(flagsIn))
    else $error("first sync stage wrong");
  sync_second_a: assert property (@(posedge mclk) disable iff (rst) // [RL16]
    !$past(rst)
    |-> s_q.flagSync2 == $past(s_q.flagSync1))
    else $error("second sync stage wrong");

endmodule : hbdpc_ctrl

/* bench/hbdpc_host_model.sv */
// host pin model: two timer port outputs feeding the drive inputs
`timescale 1ns/1ps
module hbdpc_host_model
(
  // pin setup and command
  input wire logic pinsAreOutputs,
  input wire logic [1:0] cmd,
  // pins toward the bridge
  output logic driveA,
  output logic driveB
);
  // unconfigured pins float, so the pull-down wins
  assign driveA = pinsAreOutputs ? cmd[1] : 1'b0;
  assign driveB = pinsAreOutputs ? cmd[0] : 1'b0;
endmodule : hbdpc_host_model

/* bench/tb_hbdpc_ctrl.sv */
// self-checking bench for the h-bridge drive protection controller
`timescale 1ns/1ps
module tb_hbdpc_ctrl;
  import hbdpc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pinsOut = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic driveA;
  logic driveB;
  hbdpc_flags_t flags = '0;
  hbdpc_switch_t sw;
  logic sleepPeriod;
  logic protectOff;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] rnd = 32'hBA375991;
  hbdpc_host_model host (.pinsAreOutputs(pinsOut), .cmd(cmd), .driveA(driveA), .driveB(driveB));
  hbdpc_ctrl dut (.mclk(mclk), .rst(rst), .driveInputA(driveA), .driveInputB(driveB), .flagsIn(flags),
    .switches(sw), .sleepPeriod(sleepPeriod), .protectOff(protectOff));
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // reference pattern per drive code: high a, low a, high b, low b
  function automatic logic [3:0] model(input int code);
    int tbl [4] = '{0, 6, 9, 5};
    return 4'(tbl[code]);
  endfunction : model
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask : step
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    step(5);
    rst = 1'b0;
    chk("reset", sw, 4'h0);
    pinsOut = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      rnd = lfsr(rnd);
      cmd = rnd[1:0];
      step(1);
      chk("mode", sw, model(cmd));
    end
    cmd = 2'h3;
    pinsOut = 1'b0;
    step(2);
    chk("floating", sw, 4'h0);
    pinsOut = 1'b1;
    $display("modes done");
    for (int m = 0; m < 4; m++)
    begin
      cmd = 2'(m);
      flags.overTemp = 1'b1;
      step(4);
      chk("hot", sw, 4'h0);
      chk("hot flag", {3'h0, protectOff}, 4'h1);
      flags.overTemp = 1'b0;
      step(4);
      chk("cooled", sw, model(m));
    end
    cmd = 2'h2;
    flags.supplyLockout = 1'b1;
    step(4);
    chk("lockout", sw, 4'h0);
    chk("lockout flag", {3'h0, protectOff}, 4'h1);
    cmd = 2'h1;
    step(2);
    chk("lockout input", sw, 4'h0);
    flags.supplyLockout = 1'b0;
    step(4);
    chk("supply ok", sw, 4'h6);
    // lockout in standby must not raise the protection flag
    cmd = 2'h0;
    flags.supplyLockout = 1'b1;
    step(4);
    chk("standby lockout", {3'h0, protectOff}, 4'h0);
    flags.supplyLockout = 1'b0;
    step(4);
    $display("temp and supply done");
    // a spike shorter than the deglitch time must not trip
    cmd = 2'h2;
    flags.overcurrent = 1'b1;
    step(10);
    flags.overcurrent = 1'b0;
    step(10);
    chk("oc glitch", sw, 4'h9);
    flags.overcurrent = 1'b1;
    step(30);
    chk("oc off", sw, 4'h0);
    chk("oc flag", {3'h0, protectOff}, 4'h1);
    flags.overcurrent = 1'b0;
    step(RETRY_CYC - 40);
    chk("oc hold", sw, 4'h0);
    step(60);
    chk("oc resume", sw, 4'h9);
    $display("overcurrent done");
    cmd = 2'h3;
    step(2);
    flags.shortCircuit = 1'b1;
    step(3);
    chk("short off", sw, 4'h0);
    chk("short flag", {3'h0, protectOff}, 4'h1);
    step(20);
    flags.shortCircuit = 1'b0;
    step(50);
    chk("short hold", sw, 4'h0);
    step(RETRY_CYC);
    chk("short free", sw, 4'h5);
    chk("short flag clear", {3'h0, protectOff}, 4'h0);
    // a standby fault must not carry its count into forward
    cmd = 2'h0;
    flags.overcurrent = 1'b1;
    step(30);
    chk("standby flag", {3'h0, protectOff}, 4'h0);
    chk("no early sleep", {3'h0, sleepPeriod}, 4'h0);
    cmd = 2'h2;
    step(2);
    chk("standby guard", sw, 4'h9);
    flags.overcurrent = 1'b0;
    $display("short and guard done");
    step(5);
    give_verdict();
  end
  // hang guard
  initial
  begin
    #4000000;
    mismatches++;
    give_verdict();
  end
endmodule : tb_hbdpc_ctrl
